// ==== logic/boc_object.sv ====
// Operation
// - object type enables cart, control, checks
// - open input high means open
// - close input high means closed
// - cart-in high means racked in
// - cart-out high means pulled out
// - ready at the use_ready polarity (high or low) means spring charged
// - synchrocheck high permits close
// - separate open and close command pulses
// - both inputs after traverse give Bad
// - neither input after traverse gives Intermediate
// - close waits for sync, times out
// - close pulse limited, ends on closed
// - open pulse limited, ends on open
// - no change within termination timeout errors
// - final-trip pulse, zero means continuous
// - final trip only without expected reclose
// - panel control needs configured access level
// - application close request accepted
// - sync use requires sync input active
// - ready use requires matching polarity
// - 32-bit success and fail counters
// - clear zeroes all counters
`timescale 1ns/100ps
module boc_object
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire boc_pkg::boc_type_t      object_type,
   input  wire logic [boc_pkg::STEP_W-1:0] traverse_steps,
   input  wire logic [boc_pkg::STEP_W-1:0] sync_wait_steps,
   input  wire logic [boc_pkg::STEP_W-1:0] close_pulse_steps,
   input  wire logic [boc_pkg::STEP_W-1:0] open_pulse_steps,
   input  wire logic [boc_pkg::STEP_W-1:0] term_steps,
   input  wire logic [boc_pkg::STEP_W-1:0] final_trip_steps,
   input  wire logic                    use_sync,
   input  wire boc_pkg::boc_rdy_t       use_ready,
   input  wire boc_pkg::boc_level_t     panel_level_req,
   input  wire boc_pkg::boc_level_t     panel_level,
   input  wire logic                    open_status,
   input  wire logic                    close_status,
   input  wire logic                    cart_in,
   input  wire logic                    cart_out,
   input  wire logic                    object_ready,
   input  wire logic                    sync_ok,
   input  wire logic                    local_open,
   input  wire logic                    local_close,
   input  wire logic                    remote_open,
   input  wire logic                    remote_close,
   input  wire logic                    app_close,
   input  wire logic                    panel_open,
   input  wire logic                    panel_close,
   input  wire logic                    final_trip_req,
   input  wire logic                    reclose_pending,
   input  wire logic                    clear_stats,
   output boc_pkg::boc_pos_t            breaker_status,
   output boc_pkg::boc_pos_t            cart_status,
   output logic                         cart_in_use,
   output logic                         output_relay_open,
   output logic                         output_relay_close,
   output logic                         final_trip,
   output logic                         control_error,
   output logic                         close_allowed,
   output logic [boc_pkg::CNT_W-1:0]    open_count,
   output logic [boc_pkg::CNT_W-1:0]    close_count,
   output logic [boc_pkg::CNT_W-1:0]    open_fail_count,
   output logic [boc_pkg::CNT_W-1:0]    close_fail_count
);
   typedef struct packed
   {
      boc_pkg::boc_state_t           st;
      logic [boc_pkg::PRE_W-1:0]     pre;
      logic [boc_pkg::STEP_W-1:0]    trav;
      logic [boc_pkg::STEP_W-1:0]    cmd_t;
      logic [boc_pkg::STEP_W-1:0]    ft_t;
      logic                          ft_hold;
      logic [1:0]                    last_pos;
      boc_pkg::boc_pos_t             pos;
      boc_pkg::boc_pos_t             cart;
      logic                          rel_open;
      logic                          rel_close;
      logic                          ft;
      logic                          err;
      logic [boc_pkg::CNT_W-1:0]     n_open;
      logic [boc_pkg::CNT_W-1:0]     n_close;
      logic [boc_pkg::CNT_W-1:0]     n_open_f;
      logic [boc_pkg::CNT_W-1:0]     n_close_f;
   } boc_regs_t;

   boc_regs_t r;
   boc_regs_t next_r;

   function automatic boc_pkg::boc_pos_t decode_pos
   (
      input logic act_a,
      input logic act_b
   );
      unique case ({act_b, act_a})
         2'h0: decode_pos = boc_pkg::BOC_INTERMEDIATE;
         2'h1: decode_pos = boc_pkg::BOC_OPEN;
         2'h2: decode_pos = boc_pkg::BOC_CLOSED;
         2'h3: decode_pos = boc_pkg::BOC_BAD;
      endcase
   endfunction : decode_pos

   function automatic logic [boc_pkg::CNT_W-1:0] bump
   (
      input logic [boc_pkg::CNT_W-1:0] v
   );
      bump = (v == '1) ? v : v + 1'b1;
   endfunction : bump

   logic is_breaker;
   logic can_control;
   logic panel_ok;
   logic open_req;
   logic close_req;
   logic ready_ok;
   logic tick;
   boc_pkg::boc_pos_t raw_pos;

   always_comb
   begin
      is_breaker = (object_type == boc_pkg::BOC_WD_BREAKER) ||
                   (object_type == boc_pkg::BOC_BREAKER);
      can_control = is_breaker ||
                    (object_type == boc_pkg::BOC_DISC_MC);
      panel_ok = (panel_level >= panel_level_req);
      open_req = local_open || remote_open ||
                 (panel_open && panel_ok);
      close_req = local_close || remote_close || app_close ||
                  (panel_close && panel_ok);
      unique case (use_ready)
         boc_pkg::BOC_RDY_HIGH: ready_ok = object_ready;
         boc_pkg::BOC_RDY_LOW:  ready_ok = !object_ready;
         default:               ready_ok = 1'b1;
      endcase
      raw_pos = decode_pos(open_status, close_status);
      tick = (r.pre == boc_pkg::PRE_W'(boc_pkg::STEP_CYC - 1));
   end

   always_comb
   begin
      next_r = r;
      next_r.err = 1'b0;
      next_r.pre = tick ? '0 : r.pre + 1'b1;
      // position: clean states at once, ambiguous after traverse time
      if ({close_status, open_status} != r.last_pos)
      begin
         next_r.last_pos = {close_status, open_status};
         next_r.trav = '0;
      end
      else if (tick && r.trav != '1)
         next_r.trav = r.trav + 1'b1;
      if (raw_pos == boc_pkg::BOC_OPEN || raw_pos == boc_pkg::BOC_CLOSED)
         next_r.pos = raw_pos;
      // ambiguous inputs only count once they held still
      else if ({close_status, open_status} == r.last_pos
               && r.trav >= traverse_steps)
         next_r.pos = raw_pos;
      if (object_type == boc_pkg::BOC_WD_BREAKER)
         next_r.cart = decode_pos(cart_out, cart_in);
      else
         next_r.cart = boc_pkg::BOC_INTERMEDIATE;
      if (tick && r.st != boc_pkg::BOC_IDLE)
         next_r.cmd_t = r.cmd_t + 1'b1;
      unique case (r.st)
         boc_pkg::BOC_IDLE:
         begin
            next_r.cmd_t = '0;
            if (can_control && open_req)
            begin
               next_r.st = boc_pkg::BOC_OPENING;
               next_r.rel_open = 1'b1;
            end
            else if (can_control && close_req)
            begin
               if (is_breaker && !ready_ok)
                  next_r.n_close_f = bump(r.n_close_f);
               else if (is_breaker && use_sync && !sync_ok)
                  next_r.st = boc_pkg::BOC_SYNC_WAIT;
               else
               begin
                  next_r.st = boc_pkg::BOC_CLOSING;
                  next_r.rel_close = 1'b1;
               end
            end
         end
         boc_pkg::BOC_SYNC_WAIT:
         begin
            if (sync_ok)
            begin
               next_r.st = boc_pkg::BOC_CLOSING;
               next_r.rel_close = 1'b1;
               next_r.cmd_t = '0;
            end
            else if (r.cmd_t >= sync_wait_steps)
            begin
               next_r.st = boc_pkg::BOC_IDLE;
               next_r.n_close_f = bump(r.n_close_f);
            end
         end
         boc_pkg::BOC_OPENING, boc_pkg::BOC_CLOSING:
         begin
            if ((r.st == boc_pkg::BOC_OPENING && raw_pos == boc_pkg::BOC_OPEN)
               || (r.st == boc_pkg::BOC_CLOSING
               && raw_pos == boc_pkg::BOC_CLOSED))
            begin
               next_r.st = boc_pkg::BOC_IDLE;
               next_r.rel_open = 1'b0;
               next_r.rel_close = 1'b0;
               if (r.st == boc_pkg::BOC_OPENING)
                  next_r.n_open = bump(r.n_open);
               else
                  next_r.n_close = bump(r.n_close);
            end
            else if ((r.st == boc_pkg::BOC_OPENING
               && r.cmd_t >= open_pulse_steps)
               || (r.st == boc_pkg::BOC_CLOSING
               && r.cmd_t >= close_pulse_steps))
            begin
               next_r.rel_open = 1'b0;
               next_r.rel_close = 1'b0;
               next_r.st = boc_pkg::BOC_WAIT_CHANGE;
            end
         end
         boc_pkg::BOC_WAIT_CHANGE:
         begin
            if (raw_pos != boc_pkg::BOC_INTERMEDIATE
               && raw_pos != boc_pkg::BOC_BAD && raw_pos != r.pos)
            begin
               // a late move after the pulse still counts as done
               next_r.st = boc_pkg::BOC_IDLE;
               if (raw_pos == boc_pkg::BOC_OPEN)
                  next_r.n_open = bump(r.n_open);
               else
                  next_r.n_close = bump(r.n_close);
            end
            else if (r.cmd_t >= term_steps)
            begin
               next_r.st = boc_pkg::BOC_IDLE;
               next_r.err = 1'b1;
               if (r.pos == boc_pkg::BOC_CLOSED)
                  next_r.n_open_f = bump(r.n_open_f);
               else
                  next_r.n_close_f = bump(r.n_close_f);
            end
         end
         default:
            next_r.st = boc_pkg::BOC_IDLE;
      endcase
      // final trip pulse
      if (final_trip_req && !reclose_pending)
      begin
         next_r.ft = 1'b1;
         next_r.ft_t = '0;
         next_r.ft_hold = (final_trip_steps == '0);
      end
      else if (r.ft && !r.ft_hold)
      begin
         if (tick)
            next_r.ft_t = r.ft_t + 1'b1;
         if (r.ft_t >= final_trip_steps)
            next_r.ft = 1'b0;
      end
      if (clear_stats)
      begin
         next_r.n_open = '0;
         next_r.n_close = '0;
         next_r.n_open_f = '0;
         next_r.n_close_f = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         r <= '0;
         r.st <= boc_pkg::BOC_IDLE;
         r.pos <= boc_pkg::BOC_INTERMEDIATE;
         r.cart <= boc_pkg::BOC_INTERMEDIATE;
      end
      else
         r <= next_r;
   end

   assign breaker_status = r.pos;
   assign cart_status = r.cart;
   assign cart_in_use = (object_type == boc_pkg::BOC_WD_BREAKER);
   assign output_relay_open = r.rel_open;
   assign output_relay_close = r.rel_close;
   assign final_trip = r.ft;
   assign control_error = r.err;
   assign close_allowed = is_breaker
      ? (ready_ok && (!use_sync || sync_ok)) : can_control;
   assign open_count = r.n_open;
   assign close_count = r.n_close;
   assign open_fail_count = r.n_open_f;
   assign close_fail_count = r.n_close_f;
endmodule : boc_object

// ==== logic/boc_pkg.sv ====
package boc_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   // settings are counted in 0.02 s steps
   localparam int unsigned STEP_MS = 20;
   localparam int unsigned STEP_CYC = STEP_MS * (CLK_HZ / 1000);
   localparam int STEP_W = 15;
   localparam int CNT_W = 32;
   localparam int PRE_W = 21;
   localparam logic [STEP_W-1:0] TRAVERSE_DEF = 15'h000A;
   localparam logic [STEP_W-1:0] SYNC_WAIT_DEF = 15'h000A;
   localparam logic [STEP_W-1:0] CLOSE_PULSE_DEF = 15'h000A;
   localparam logic [STEP_W-1:0] OPEN_PULSE_DEF = 15'h000A;
   localparam logic [STEP_W-1:0] TERM_DEF = 15'h01F4;
   localparam logic [STEP_W-1:0] FINAL_TRIP_DEF = 15'h000A;

   typedef enum logic [1:0]
   {
      BOC_WD_BREAKER,
      BOC_BREAKER,
      BOC_DISC_MC,
      BOC_DISC_GND
   } boc_type_t;

   typedef enum logic [1:0]
   {
      BOC_INTERMEDIATE,
      BOC_OPEN,
      BOC_CLOSED,
      BOC_BAD
   } boc_pos_t;

   typedef enum logic [1:0]
   {
      BOC_USER,
      BOC_OPERATOR,
      BOC_CONFIGURATOR,
      BOC_SUPER_USER
   } boc_level_t;

   localparam boc_level_t LEVEL_DEF = BOC_CONFIGURATOR;

   typedef enum logic [1:0]
   {
      BOC_RDY_OFF,
      BOC_RDY_HIGH,
      BOC_RDY_LOW
   } boc_rdy_t;

   typedef enum logic [2:0]
   {
      BOC_IDLE,
      BOC_SYNC_WAIT,
      BOC_CLOSING,
      BOC_OPENING,
      BOC_WAIT_CHANGE
   } boc_state_t;
endpackage : boc_pkg

// ==== testbench/boc_breaker_model.sv ====
`timescale 1ns/100ps
module boc_breaker_model
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       relay_open,
   input  wire logic       relay_close,
   input  wire logic [7:0] lag,
   input  wire logic       stuck,
   output logic            open_status,
   output logic            close_status
);
   logic       closed;
   logic [7:0] cnt;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         closed <= 1'b0;
         cnt    <= 8'h00;
      end
      else if (relay_open | relay_close)
      begin
         cnt <= (cnt < lag) ? cnt + 8'h01 : cnt;
         if (cnt == lag)
            closed <= relay_close;
      end
      else
         cnt <= 8'h00;
   end
   // both contacts drop while the mechanism travels; stuck welds both on
   assign open_status  = stuck
      || (!closed && !(relay_close && cnt != 8'h00));
   assign close_status = stuck
      || (closed && !(relay_open && cnt != 8'h00));
endmodule : boc_breaker_model

// ==== testbench/boc_object_assertions.sv ====
`timescale 1ns/100ps
module boc_object_assertions
(
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire boc_pkg::boc_type_t   object_type,
   input wire logic                 use_sync,
   input wire boc_pkg::boc_rdy_t    use_ready,
   input wire logic                 object_ready,
   input wire logic                 sync_ok,
   input wire logic                 open_status,
   input wire logic                 close_status,
   input wire logic                 clear_stats,
   input wire boc_pkg::boc_pos_t    breaker_status,
   input wire boc_pkg::boc_pos_t    cart_status,
   input wire logic                 output_relay_open,
   input wire logic                 output_relay_close,
   input wire logic                 close_allowed,
   input wire logic [31:0]          open_count,
   input wire logic [31:0]          close_count
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   chk_pos_open: assert property ((open_status && !close_status)[*3]
      |-> breaker_status == boc_pkg::BOC_OPEN) else $error("open not shown");
   chk_pos_closed: assert property ((close_status && !open_status)[*3]
      |-> breaker_status == boc_pkg::BOC_CLOSED) else $error("closed not shown");
   chk_relay_excl: assert property (!(output_relay_open && output_relay_close))
      else $error("both relays driven");
   chk_close_end: assert property (output_relay_close && close_status
      |-> ##[1:2] !output_relay_close) else $error("close pulse not ended");
   chk_open_end: assert property (output_relay_open && open_status
      |-> ##[1:2] !output_relay_open) else $error("open pulse not ended");
   chk_sync_gate: assert property (use_sync && !sync_ok
      && object_type <= boc_pkg::BOC_BREAKER |-> !close_allowed)
      else $error("close allowed without sync");
   chk_ready_gate: assert property (use_ready == boc_pkg::BOC_RDY_HIGH
      && !object_ready && object_type <= boc_pkg::BOC_BREAKER |-> !close_allowed)
      else $error("close allowed while not ready");
   chk_rise_gate: assert property ($rose(output_relay_close)
      |-> $past(close_allowed)) else $error("close relay without permission");
   chk_cart_unused: assert property ((object_type != boc_pkg::BOC_WD_BREAKER)[*2]
      |-> cart_status == boc_pkg::BOC_INTERMEDIATE) else $error("cart shown");
   chk_clear_zero: assert property (clear_stats
      |=> open_count == 32'h0 && close_count == 32'h0) else $error("not cleared");
   cover property ($rose(output_relay_close));
   cover property ($rose(output_relay_open));
   cover property (clear_stats);
endmodule : boc_object_assertions
bind boc_object boc_object_assertions boc_object_assertions_inst
(
   .ref_clk, .rst, .object_type, .use_sync, .use_ready, .object_ready,
   .sync_ok, .open_status, .close_status, .clear_stats, .breaker_status,
   .cart_status, .output_relay_open, .output_relay_close, .close_allowed,
   .open_count, .close_count
);

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
   logic                ref_clk = 1'b0, rst = 1'b1, use_sync = 1'b0;
   boc_pkg::boc_type_t  object_type = boc_pkg::BOC_BREAKER;
   boc_pkg::boc_rdy_t   use_ready = boc_pkg::BOC_RDY_OFF;
   boc_pkg::boc_level_t panel_level = boc_pkg::BOC_SUPER_USER;
   boc_pkg::boc_level_t panel_level_req = boc_pkg::LEVEL_DEF;
   logic [14:0]         ft_steps = 15'h0000;
   logic [14:0]         trav_lim = boc_pkg::TRAVERSE_DEF;
   logic [14:0]         lim = boc_pkg::CLOSE_PULSE_DEF;
   logic [14:0]         term_lim = boc_pkg::TERM_DEF;
   logic                stuck = 1'b0, control_error;
   logic                cart_in = 1'b0, cart_out = 1'b0, object_ready = 1'b1;
   logic                sync_ok = 1'b0, final_trip_req = 1'b0;
   logic                reclose_pending = 1'b0, clear_stats = 1'b0;
   logic [6:0]          req = 7'h00;
   logic [7:0]          lag = 8'h05;
   logic                open_status, close_status, relay_open, relay_close;
   logic                final_trip, close_allowed, cart_in_use;
   boc_pkg::boc_pos_t   breaker_status, cart_status;
   logic [31:0]         open_count, close_count, open_fail, close_fail;
   int                  error_cnt = 0, checked = 0, cyc = 0;
   // type, use_sync, sync_ok, use_ready, expected close_allowed
   logic [6:0]          rows [8] = '{7'h21, 7'h30, 7'h39, 7'h23, 7'h24,
                                     7'h60, 7'h51, 7'h10};
   boc_object boc_object_inst
   (
      .ref_clk, .rst, .object_type, .use_sync, .use_ready, .panel_level,
      .panel_level_req, .open_status, .close_status, .cart_in, .cart_out,
      .object_ready, .sync_ok, .final_trip_req, .reclose_pending,
      .clear_stats, .breaker_status, .cart_status, .cart_in_use,
      .final_trip, .close_allowed, .open_count, .close_count,
      .traverse_steps(trav_lim), .sync_wait_steps(lim),
      .close_pulse_steps(lim), .open_pulse_steps(lim),
      .term_steps(term_lim), .final_trip_steps(ft_steps),
      .local_close(req[0]), .local_open(req[1]), .remote_close(req[2]),
      .remote_open(req[3]), .app_close(req[4]), .panel_open(req[5]),
      .panel_close(req[6]), .output_relay_open(relay_open),
      .output_relay_close(relay_close), .control_error,
      .open_fail_count(open_fail), .close_fail_count(close_fail)
   );
   boc_breaker_model boc_breaker_model_inst
   (
      .ref_clk, .rst, .relay_open, .relay_close, .lag, .open_status,
      .close_status, .stuck
   );
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   task conclude;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         conclude();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
         error_cnt++;
      end
   endtask : chk
   task pulse(input logic [6:0] v);
      @(negedge ref_clk) req = v;
      @(negedge ref_clk) req = 7'h00;
      @(negedge ref_clk);
   endtask : pulse
   // even index closes, odd index opens
   task op(input int i);
      pulse(7'h01 << i);
      chk(i[0] ? relay_open : relay_close, 1'b1);
      repeat (30) @(negedge ref_clk);
      chk({relay_open, relay_close}, 2'b00);
      chk(breaker_status, i[0] ? 2'h1 : 2'h2);
   endtask : op
   initial
   begin
      repeat (20) @(negedge ref_clk);
      chk({breaker_status, relay_open, relay_close, final_trip}, 0);
      rst = 1'b0;
      foreach (rows[i])
      begin
         @(negedge ref_clk);
         object_type = boc_pkg::boc_type_t'(rows[i][6:5]);
         {use_sync, sync_ok} = rows[i][4:3];
         use_ready = boc_pkg::boc_rdy_t'(rows[i][2:1]);
         @(negedge ref_clk);
         chk(close_allowed, rows[i][0]);
      end
      object_type = boc_pkg::BOC_BREAKER;
      use_sync = 1'b0;
      use_ready = boc_pkg::BOC_RDY_OFF;
      $display("gating table done");
      for (int i = 0; i < 7; i++) op(i);
      chk(open_count, 32'h3);
      chk(close_count, 32'h4);
      panel_level = boc_pkg::BOC_USER;
      pulse(7'h20);
      chk(relay_open, 1'b0);
      panel_level = boc_pkg::BOC_SUPER_USER;
      op(1);
      $display("sources and access done");
      use_ready = boc_pkg::BOC_RDY_HIGH;
      object_ready = 1'b0;
      pulse(7'h01);
      chk(relay_close, 1'b0);
      chk(close_fail, 32'h1);
      use_ready = boc_pkg::BOC_RDY_OFF;
      object_ready = 1'b1;
      use_sync = 1'b1;
      pulse(7'h01);
      repeat (3) @(negedge ref_clk);
      chk(relay_close, 1'b0);
      sync_ok = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(relay_close, 1'b1);
      repeat (30) @(negedge ref_clk);
      chk(close_count, 32'h5);
      $display("ready and sync done");
      clear_stats = 1'b1;
      @(negedge ref_clk) clear_stats = 1'b0;
      chk(open_count | close_count | open_fail | close_fail, 0);
      op(1);
      chk(open_count, 32'h1);
      {reclose_pending, final_trip_req} = 2'h3;
      @(negedge ref_clk) final_trip_req = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(final_trip, 1'b0);
      {reclose_pending, final_trip_req} = 2'h1;
      @(negedge ref_clk) final_trip_req = 1'b0;
      repeat (50) @(negedge ref_clk);
      chk(final_trip, 1'b1);
      $display("clear and final trip done");
      object_type = boc_pkg::BOC_WD_BREAKER;
      cart_in = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({cart_in_use, cart_status}, 3'h6);
      {cart_in, cart_out} = 2'h1;
      repeat (4) @(negedge ref_clk);
      chk(cart_status, 2'h1);
      $display("cart done");
      trav_lim = 15'h0000;
      pulse(7'h01);
      repeat (2) @(negedge ref_clk);
      chk(breaker_status, boc_pkg::BOC_INTERMEDIATE);
      repeat (30) @(negedge ref_clk);
      chk(breaker_status, boc_pkg::BOC_CLOSED);
      trav_lim = boc_pkg::TRAVERSE_DEF;
      stuck = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(breaker_status, boc_pkg::BOC_CLOSED);
      trav_lim = 15'h0000;
      repeat (2) @(negedge ref_clk);
      chk(breaker_status, boc_pkg::BOC_BAD);
      stuck = 1'b0;
      trav_lim = boc_pkg::TRAVERSE_DEF;
      $display("traverse done");
      lim = 15'h0000;
      sync_ok = 1'b0;
      pulse(7'h01);
      chk(relay_close, 1'b0);
      chk(close_fail, 32'h1);
      pulse(7'h02);
      chk(relay_open, 1'b0);
      repeat (3) @(negedge ref_clk);
      chk(control_error, 1'b0);
      term_lim = 15'h0000;
      @(negedge ref_clk);
      chk(control_error, 1'b1);
      chk(open_fail, 32'h1);
      @(negedge ref_clk);
      chk(control_error, 1'b0);
      $display("timeouts done");
      conclude();
   end
endmodule : tb
